// ### testbench/uvc_config_regs_bench.sv
// Self-checking bench for the receive-chain register bank.
`timescale 1ns/100ps
`default_nettype none
module uvc_config_regs_bench;
  // ---------------------------------------------------------------------------
  // Signals and model
  // ---------------------------------------------------------------------------
  logic i_clk, i_rst_n, i_wr, i_rd;
  logic [7:0] i_addr;
  logic [15:0] i_wdata, o_rdata, o_gain;
  logic [1:0] o_mode, o_sleep, o_mult, o_hpf;
  logic o_ag_off, o_amp_off, o_fast, o_base, o_path, o_sum_on, o_route, o_res;
  logic [4:0] o_sgain, o_term;
  logic [31:0] o_phase;
  logic [2:0] o_att;
  int err_count, n_tests;
  logic [31:0] seed;
  logic [15:0] m [0:7];
  logic [15:0] pwr_tab [0:5] = '{16'hC000, 16'h4000, 16'h0C00, 16'h0800, 16'h0400, 16'h3000};
  uvc_config_regs i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .o_power_mode(o_mode), .o_atten_gain_stage_off(o_ag_off),
    .o_input_amp_off(o_amp_off), .o_chain_sleep(o_sleep), .o_doppler_summer_gain(o_sgain),
    .o_doppler_fast_clock_type(o_fast), .o_doppler_base_clock_type(o_base), .o_path_select(o_path),
    .o_doppler_summer_on(o_sum_on), .o_doppler_clock_multiple(o_mult), .o_gain_stage_test_route(o_route),
    .o_channel_mixer_phase(o_phase), .o_channel_input_gain(o_gain), .o_gain_reserved(o_res),
    .o_input_highpass_corner(o_hpf), .o_digital_atten_step(o_att), .o_termination_resistors(o_term));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Index 6 is the unmapped hole at 0x3A, so its mask is zero.
  function automatic logic [15:0] msk(input int k);
    case (k)
      0: return uvc_pkg::MASK_TERMINATION;
      1: return uvc_pkg::MASK_CHAIN_POWER;
      2: return uvc_pkg::MASK_CW_PATH;
      3, 4, 5: return uvc_pkg::MASK_FULL;
      7: return uvc_pkg::MASK_FILTER_ATTEN;
      default: return 16'h0000;
    endcase
  endfunction
  // Any enabled per-channel gain field holding the reserved code raises the flag.
  function automatic logic exp_rsv();
    logic r;
    r = 1'b0;
    for (int n = 0; n < 8; n++) r = r | (m[5][2*n +: 2] == uvc_pkg::GAIN_CODE_RESERVED);
    return r && m[0][15];
  endfunction
  task automatic complete_run();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk_rd(input logic [15:0] exp);
    n_tests++;
    if (o_rdata !== exp) begin
      err_count++;
      $display("mismatch at %0t: read %h expected %h", $time, o_rdata, exp);
    end
  endtask
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: output %h expected %h", $time, got, exp);
    end
  endtask
  // Each access ends 1 ns after its edge so the next one is back to back.
  task automatic wr(input int k, input logic [15:0] d);
    i_wr <= 1'b1;
    i_addr <= uvc_pkg::ADDR_TERMINATION + 8'(k);
    i_wdata <= d;
    m[k] = d & msk(k);
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input int k);
    i_rd <= 1'b1;
    i_addr <= uvc_pkg::ADDR_TERMINATION + 8'(k);
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk_rd(m[k]);
  endtask
  task automatic chk_cfg();
    chk_out(o_sum_on, !m[2][9] && m[7][8]);
    chk_out(o_gain, m[0][15] ? m[5] : 16'h0000);
    chk_out(o_phase, {m[4], m[3]});
    chk_out(o_att, m[7][7] ? m[7][6:4] : 3'h0);
    chk_out({o_mult, o_path}, {m[2][11:10], m[2][8]});
    chk_out(o_sleep, m[1][15] ? 2'h2 : {1'b0, m[1][14]});
    chk_out({o_amp_off, o_ag_off}, m[1][13:12]);
    chk_out({o_base, o_fast, o_sgain}, m[2][6:0]);
    chk_out({o_route, o_hpf}, {m[7][9], m[7][3:2]});
    chk_out(o_res, exp_rsv());
    chk_out(o_mode, m[1][11:10] == 2'h2 ? 2'h1 : (m[1][11:10] == 2'h1 ? 2'h2 : 2'h0));
    if (m[0][4:0] != 5'h00) begin
      chk_out(o_term, m[0][4:0]);
    end
  endtask
  task automatic reset_and_read();
    for (int k = 0; k < 8; k++) m[k] = 16'h0000;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 8; k++) rd(k);
    chk_out(o_term, 5'h0B);
  endtask
  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge i_clk);
    err_count++;
    $display("mismatch at %0t: run limit reached", $time);
    complete_run();
  end
  initial begin
    {i_rst_n, i_wr, i_rd, i_addr, i_wdata} = '0;
    err_count = 0;
    n_tests = 0;
    seed = 32'h57E07E54;
    reset_and_read();
    for (int k = 0; k < 8; k++) begin
      wr(k, 16'hFFFF);
      rd(k);
      chk_cfg();
    end
    for (int j = 0; j < 6; j++) begin
      wr(1, pwr_tab[j]);
      chk_cfg();
    end
    for (int j = 0; j < 400; j++) begin
      seed = xs(seed);
      wr(int'(seed[2:0]), seed[31:16]);
      if (seed[3]) rd(int'(seed[2:0]));
      chk_cfg();
    end
    // A second reset at the end of the run must bring every register back to zero and the termination output back to 0x0B.
    i_rst_n <= 1'b0;
    reset_and_read();
    complete_run();
  end
endmodule
`default_nettype wire

// ### testbench/uvc_config_regs_properties.sv
// Concurrent checks on the ports of the receive-chain register bank.
`timescale 1ns/100ps
`default_nettype none
module uvc_config_regs_properties #(
  parameter int CHANNELS = 8
) (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Decoded settings
  input wire logic [1:0] o_power_mode,
  input wire logic o_atten_gain_stage_off,
  input wire logic o_input_amp_off,
  input wire logic [1:0] o_chain_sleep,
  input wire logic [4:0] o_doppler_summer_gain,
  input wire logic o_doppler_fast_clock_type,
  input wire logic o_doppler_base_clock_type,
  input wire logic o_path_select,
  input wire logic [1:0] o_doppler_clock_multiple,
  input wire logic o_gain_stage_test_route,
  input wire logic [4*CHANNELS-1:0] o_channel_mixer_phase,
  input wire logic [2*CHANNELS-1:0] o_channel_input_gain,
  input wire logic o_gain_reserved,
  input wire logic [1:0] o_input_highpass_corner,
  input wire logic [2:0] o_digital_atten_step,
  input wire logic [4:0] o_termination_resistors
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  logic res_any;
  always_comb begin
    res_any = 1'b0;
    for (int n = 0; n < CHANNELS; n++) begin
      res_any = res_any | (o_channel_input_gain[2*n +: 2] == 2'h3);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_wr(logic [7:0] a);
    i_wr && i_addr == a;
  endsequence
  // A read of a stored register; every other cycle must leave the read data at zero.
  logic rd_mapped;
  assign rd_mapped = i_rd && (i_addr inside {[uvc_pkg::ADDR_TERMINATION:uvc_pkg::ADDR_INPUT_GAIN],
    uvc_pkg::ADDR_FILTER_ATTEN});
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  a_power_mode_map: assert property (s_wr(uvc_pkg::ADDR_CHAIN_POWER) |=>
    o_power_mode == ($past(i_wdata[11:10]) == 2'h2 ? 2'h1 : ($past(i_wdata[11:10]) == 2'h1 ? 2'h2 : 2'h0)))
    else $error("power mode does not follow the written bits");
  a_stage_off_bits: assert property (s_wr(uvc_pkg::ADDR_CHAIN_POWER) |=>
    {o_input_amp_off, o_atten_gain_stage_off} == $past(i_wdata[13:12])) else $error("stage power-down bits wrong");
  a_full_sleep_wins: assert property (s_wr(uvc_pkg::ADDR_CHAIN_POWER) |=>
    o_chain_sleep == ($past(i_wdata[15]) ? 2'h2 : {1'b0, $past(i_wdata[14])})) else $error("sleep state wrong");
  a_cw_path_fields: assert property (s_wr(uvc_pkg::ADDR_CW_PATH) |=>
    {o_doppler_clock_multiple, o_path_select, o_doppler_base_clock_type, o_doppler_fast_clock_type,
     o_doppler_summer_gain} == {$past(i_wdata[11:10]), $past(i_wdata[8]), $past(i_wdata[6:0])})
    else $error("Doppler path fields wrong");
  a_cw_keeps_stages: assert property (s_wr(uvc_pkg::ADDR_CW_PATH) |=>
    $stable(o_atten_gain_stage_off)) else $error("path write moved stage power-down");
  a_phase_low_half: assert property (s_wr(uvc_pkg::ADDR_PHASE_LOW) |=>
    o_channel_mixer_phase[15:0] == $past(i_wdata)) else $error("low channel phases wrong");
  a_phase_high_half: assert property (s_wr(uvc_pkg::ADDR_PHASE_HIGH) |=>
    o_channel_mixer_phase[31:16] == $past(i_wdata)) else $error("high channel phases wrong");
  a_filter_fields: assert property (s_wr(uvc_pkg::ADDR_FILTER_ATTEN) |=>
    {o_gain_stage_test_route, o_input_highpass_corner} == {$past(i_wdata[9]), $past(i_wdata[3:2])} &&
    o_digital_atten_step == ($past(i_wdata[7]) ? $past(i_wdata[6:4]) : 3'h0)) else $error("filter fields wrong");
  a_rdata_quiet: assert property (!rd_mapped |=> o_rdata == 16'h0000) else $error("read data not zero");
  a_config_holds: assert property (!i_wr |=> $stable({o_power_mode, o_chain_sleep,
    o_channel_mixer_phase, o_channel_input_gain, o_termination_resistors})) else $error("setting moved without write");
  a_reserved_flag: assert property (o_gain_reserved == res_any) else $error("reserved gain flag wrong");
endmodule
bind uvc_config_regs uvc_config_regs_properties #(.CHANNELS(CHANNELS)) i_props (.i_clk(i_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_power_mode(o_power_mode),
  .o_atten_gain_stage_off(o_atten_gain_stage_off), .o_input_amp_off(o_input_amp_off), .o_chain_sleep(o_chain_sleep),
  .o_doppler_summer_gain(o_doppler_summer_gain), .o_doppler_fast_clock_type(o_doppler_fast_clock_type),
  .o_doppler_base_clock_type(o_doppler_base_clock_type), .o_path_select(o_path_select),
  .o_doppler_clock_multiple(o_doppler_clock_multiple), .o_gain_stage_test_route(o_gain_stage_test_route),
  .o_channel_mixer_phase(o_channel_mixer_phase), .o_channel_input_gain(o_channel_input_gain),
  .o_gain_reserved(o_gain_reserved), .o_input_highpass_corner(o_input_highpass_corner),
  .o_digital_atten_step(o_digital_atten_step), .o_termination_resistors(o_termination_resistors));
`default_nettype wire

// ### verilog/uvc_config_regs.sv
// Register bank that steers power, Doppler, gain, filter and termination settings of the receive chain.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module uvc_config_regs #(
  parameter int CHANNELS = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Chain power
  output logic [1:0] o_power_mode,
  output logic o_atten_gain_stage_off,
  output logic o_input_amp_off,
  output logic [1:0] o_chain_sleep,
  // Doppler path
  output logic [4:0] o_doppler_summer_gain,
  output logic o_doppler_fast_clock_type,
  output logic o_doppler_base_clock_type,
  output logic o_path_select,
  output logic o_doppler_summer_on,
  output logic [1:0] o_doppler_clock_multiple,
  output logic o_gain_stage_test_route,
  output logic [4*CHANNELS-1:0] o_channel_mixer_phase,
  // Input amplifier and filter
  output logic [2*CHANNELS-1:0] o_channel_input_gain,
  output logic o_gain_reserved,
  output logic [1:0] o_input_highpass_corner,
  output logic [2:0] o_digital_atten_step,
  // Termination, same for both paths
  output logic [4:0] o_termination_resistors
);

  // ---------------------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------------------
  localparam int NREG = 7;

  logic [15:0] reg_r [NREG];
  logic [15:0] rdata_r;
  logic [NREG-1:0] hit;

  function automatic logic [7:0] reg_addr(input int idx);
    logic [7:0] a;
    a = uvc_pkg::ADDR_TERMINATION;
    unique case (idx)
      1: a = uvc_pkg::ADDR_CHAIN_POWER;
      2: a = uvc_pkg::ADDR_CW_PATH;
      3: a = uvc_pkg::ADDR_PHASE_LOW;
      4: a = uvc_pkg::ADDR_PHASE_HIGH;
      5: a = uvc_pkg::ADDR_INPUT_GAIN;
      6: a = uvc_pkg::ADDR_FILTER_ATTEN;
      default: a = uvc_pkg::ADDR_TERMINATION;
    endcase
    return a;
  endfunction

  // Only documented bits are stored; reserved bits read back as zero.
  function automatic logic [15:0] reg_mask(input int idx);
    logic [15:0] m;
    m = uvc_pkg::MASK_FULL;
    unique case (idx)
      0: m = uvc_pkg::MASK_TERMINATION;
      1: m = uvc_pkg::MASK_CHAIN_POWER;
      2: m = uvc_pkg::MASK_CW_PATH;
      6: m = uvc_pkg::MASK_FILTER_ATTEN;
      default: m = uvc_pkg::MASK_FULL;
    endcase
    return m;
  endfunction

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      assign hit[gi] = (i_addr == reg_addr(gi));
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          reg_r[gi] <= uvc_pkg::RESET_VALUE;
        end else if (i_wr && hit[gi]) begin
          reg_r[gi] <= i_wdata & reg_mask(gi);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------------------
  logic [15:0] rd_sel;

  always_comb begin
    rd_sel = 16'h0000;
    for (int k = 0; k < NREG; k++) begin
      if (hit[k]) begin
        rd_sel = reg_r[k];
      end
    end
  end

  // Unmapped addresses read as zero; data stands only in the cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_r <= uvc_pkg::RESET_VALUE;
    end else begin
      rdata_r <= i_rd ? rd_sel : 16'h0000;
    end
  end

  assign o_rdata = rdata_r;

  // ---------------------------------------------------------------------------
  // Chain power decode
  // ---------------------------------------------------------------------------
  wire [15:0] pwr = reg_r[1];
  wire [15:0] cwp = reg_r[2];
  wire [15:0] flt = reg_r[6];
  wire [15:0] term = reg_r[0];

  wire med_sel = pwr[uvc_pkg::MEDIUM_CONSUMPTION_SELECT_BIT];
  wire low_sel = pwr[uvc_pkg::LOW_POWER_BIT];

  // Both mode bits set is not a legal combination, so the chain stays low-noise.
  assign o_power_mode = (med_sel && !low_sel) ? uvc_pkg::UVC_MODE_MEDIUM :
                        (low_sel && !med_sel) ? uvc_pkg::UVC_MODE_LOW_POWER :
                        uvc_pkg::UVC_MODE_LOW_NOISE;

  // Doppler mode does not switch the attenuator off by itself; software uses this bit.
  assign o_atten_gain_stage_off = pwr[uvc_pkg::ATT_GAIN_OFF_BIT];
  assign o_input_amp_off = pwr[uvc_pkg::INPUT_AMP_OFF_BIT];

  assign o_chain_sleep = pwr[uvc_pkg::FULL_SLEEP_BIT] ? uvc_pkg::UVC_SLEEP_FULL :
                         pwr[uvc_pkg::PARTIAL_SLEEP_BIT] ? uvc_pkg::UVC_SLEEP_PARTIAL :
                         uvc_pkg::UVC_SLEEP_NONE;

  // ---------------------------------------------------------------------------
  // Doppler path decode
  // ---------------------------------------------------------------------------
  assign o_doppler_summer_gain = cwp[uvc_pkg::SUMMER_GAIN_LSB +: 5];
  assign o_doppler_fast_clock_type = cwp[uvc_pkg::FAST_CLK_TYPE_BIT];
  assign o_doppler_base_clock_type = cwp[uvc_pkg::BASE_CLK_TYPE_BIT];
  assign o_path_select = cwp[uvc_pkg::PATH_SELECT_BIT];
  assign o_doppler_clock_multiple = cwp[uvc_pkg::CLOCK_MULT_LSB +: 2];

  // The summer runs only when its active-low enable is clear and its power bit is set.
  assign o_doppler_summer_on = !cwp[uvc_pkg::SUMMER_DISABLE_BIT]
                               && flt[uvc_pkg::SUMMER_POWER_BIT];

  assign o_gain_stage_test_route = flt[uvc_pkg::TEST_ROUTE_BIT];

  // Channel phases; channels past the fourth live in the high-channel register.
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_phase
      if (gi < 4) begin : g_lo
        assign o_channel_mixer_phase[4*gi +: 4] = reg_r[3][4*gi +: 4];
      end else begin : g_hi
        assign o_channel_mixer_phase[4*gi +: 4] = reg_r[4][4*(gi-4) +: 4];
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Input amplifier gain and filter decode
  // ---------------------------------------------------------------------------
  // Individual gains only apply while the enable bit is set; otherwise the 18 dB code.
  wire indiv = term[uvc_pkg::INDIV_GAIN_BIT];
  logic [CHANNELS-1:0] rsv;

  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_gain
      assign o_channel_input_gain[2*gi +: 2] = indiv ? reg_r[5][2*gi +: 2] : 2'h0;
      assign rsv[gi] = indiv && (reg_r[5][2*gi +: 2] == uvc_pkg::GAIN_CODE_RESERVED);
    end
  endgenerate

  assign o_gain_reserved = |rsv;

  assign o_input_highpass_corner = flt[uvc_pkg::HPF_LSB +: 2];

  // Step is forced to zero while the attenuator is disabled.
  assign o_digital_atten_step = flt[uvc_pkg::ATT_ENABLE_BIT] ? flt[uvc_pkg::ATT_STEP_LSB +: 3] : 3'h0;

  // ---------------------------------------------------------------------------
  // Termination
  // ---------------------------------------------------------------------------
  // The preset decoder uses channel one's gain as the common gain reference.
  uvc_term_decoder u_term (
    .i_preset(term[uvc_pkg::TERM_PRESET_LSB +: 2]),
    .i_gain(o_channel_input_gain[1:0]),
    .i_manual(term[uvc_pkg::TERM_RES_LSB +: 5]),
    .o_resistors(o_termination_resistors)
  );

endmodule
`default_nettype wire

// ### verilog/uvc_pkg.sv
// Package with register offsets, field positions and reset values for the receive-chain control bank.
// Overview of operation
// - Register 53 bit 11 set, bit 10 clear selects medium-power mode; else low-noise.
// - Register 53 bit 10 set, bit 11 clear selects low-power mode; else low-noise.
// - Register 53 bit 12 powers down attenuator and gain stage together.
// - Register 53 bit 13 powers down only the input amplifier.
// - Register 53 bit 14 puts the chain in partial, fast-wake power-down.
// - Register 53 bit 15 fully powers down the chain and overrides partial power-down.
// - Register 54 bits 4:0 pick summing-amplifier feedback resistors, setting its gain.
// - Register 54 bit 5: fast clock input, 0 differential, 1 single-ended.
// - Register 54 bit 6: base clock input, 0 single-ended, 1 differential.
// - Register 54 bit 8 selects imaging path (0) or Doppler path (1).
// - Register 54 bit 9 is an active-low summing-amplifier enable.
// - Register 54 bits 11:10 set clock multiple: 16x, 8x, 4x, 1x.
// - Four-bit mixer phase per channel; registers 55 and 56, lowest channel lowest nibble.
// - Register 57 holds two-bit input gain per channel: 18, 24, 12 dB, reserved.
// - Register 59 bits 3:2 choose input high-pass corner 100, 50, 200, 150 kHz.
// - Register 59 bit 7 enables digital attenuator; bits 6:4 give N times 6 dB.
// - Register 59 bit 8 powers the summing amplifier: 0 off, 1 on.
// - Register 59 bit 9 routes gain-stage outputs to Doppler outputs for test.
// - Register 52 bits 4:0 each enable one termination resistor; zero enables none. Here zero selects the preset from bits 7:6 instead.
// - Termination setting applies equally to imaging and Doppler paths.
// - Register 52 bits 7:6 pick a preset termination matched to input gain.
package uvc_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADDR_TERMINATION = 8'h34;
  localparam logic [7:0] ADDR_CHAIN_POWER = 8'h35;
  localparam logic [7:0] ADDR_CW_PATH = 8'h36;
  localparam logic [7:0] ADDR_PHASE_LOW = 8'h37;
  localparam logic [7:0] ADDR_PHASE_HIGH = 8'h38;
  localparam logic [7:0] ADDR_INPUT_GAIN = 8'h39;
  localparam logic [7:0] ADDR_FILTER_ATTEN = 8'h3B;

  // ---------------------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  localparam logic [15:0] MASK_TERMINATION = 16'h80DF;
  localparam logic [15:0] MASK_CHAIN_POWER = 16'hFC00;
  localparam logic [15:0] MASK_CW_PATH = 16'h0F7F;
  localparam logic [15:0] MASK_FULL = 16'hFFFF;
  localparam logic [15:0] MASK_FILTER_ATTEN = 16'h03FC;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int TERM_RES_LSB = 0;
  localparam int TERM_PRESET_LSB = 6;
  localparam int INDIV_GAIN_BIT = 15;
  localparam int LOW_POWER_BIT = 10;
  localparam int MEDIUM_CONSUMPTION_SELECT_BIT = 11;
  localparam int ATT_GAIN_OFF_BIT = 12;
  localparam int INPUT_AMP_OFF_BIT = 13;
  localparam int PARTIAL_SLEEP_BIT = 14;
  localparam int FULL_SLEEP_BIT = 15;
  localparam int SUMMER_GAIN_LSB = 0;
  localparam int FAST_CLK_TYPE_BIT = 5;
  localparam int BASE_CLK_TYPE_BIT = 6;
  localparam int PATH_SELECT_BIT = 8;
  localparam int SUMMER_DISABLE_BIT = 9;
  localparam int CLOCK_MULT_LSB = 10;
  localparam int HPF_LSB = 2;
  localparam int ATT_STEP_LSB = 4;
  localparam int ATT_ENABLE_BIT = 7;
  localparam int SUMMER_POWER_BIT = 8;
  localparam int TEST_ROUTE_BIT = 9;

  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    UVC_MODE_LOW_NOISE = 2'h0,
    UVC_MODE_MEDIUM = 2'h1,
    UVC_MODE_LOW_POWER = 2'h2
  } uvc_power_mode_e;

  typedef enum logic [1:0] {
    UVC_SLEEP_NONE = 2'h0,
    UVC_SLEEP_PARTIAL = 2'h1,
    UVC_SLEEP_FULL = 2'h2
  } uvc_sleep_e;

  localparam logic [1:0] GAIN_CODE_RESERVED = 2'h3;

endpackage

// ### verilog/uvc_term_decoder.sv
// Preset termination decoder: maps a preset and input gain onto feedback resistor enables.
`timescale 1ns/100ps
`default_nettype none
module uvc_term_decoder (
  // Preset and gain
  input wire logic [1:0] i_preset,
  input wire logic [1:0] i_gain,
  // Manual resistor selection
  input wire logic [4:0] i_manual,
  // Resistor enables
  output logic [4:0] o_resistors
);

  // Presets pick one to five resistors that give roughly 50, 100, 200 and 400 ohm at each gain.
  // The manual field wins whenever any of its bits is set, so software keeps full control.
  logic [4:0] preset_sel;

  always_comb begin
    preset_sel = 5'h00;
    unique case ({i_preset, i_gain})
      4'h0: preset_sel = 5'h0B;
      4'h1: preset_sel = 5'h01;
      4'h2: preset_sel = 5'h1F;
      4'h3: preset_sel = 5'h0B;
      4'h4: preset_sel = 5'h02;
      4'h5: preset_sel = 5'h02;
      4'h6: preset_sel = 5'h03;
      4'h7: preset_sel = 5'h02;
      4'h8: preset_sel = 5'h12;
      4'h9: preset_sel = 5'h04;
      4'hA: preset_sel = 5'h06;
      4'hB: preset_sel = 5'h12;
      4'hC: preset_sel = 5'h18;
      4'hD: preset_sel = 5'h0C;
      4'hE: preset_sel = 5'h0C;
      4'hF: preset_sel = 5'h18;
    endcase
  end

  assign o_resistors = (i_manual != 5'h00) ? i_manual : preset_sel;

endmodule
`default_nettype wire
